// [core/code_fifo.v]
// synchronous fifo carrying captured codes to the decoder
`timescale 1ns/100ps
`default_nettype none

module code_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 32
) (
   // clock and reset
   input  wire             i_ref_clk,
   input  wire             i_rst,
   // fill side
   input  wire             i_in_valid,
   output wire             o_in_ready,
   input  wire [WIDTH-1:0] i_in_data,
   // drain side
   output wire             o_out_valid,
   input  wire             i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);

   localparam AW = $clog2(DEPTH);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;

   wire push = i_in_valid & o_in_ready;
   wire pop  = o_out_valid & i_out_ready;

   // honest flags straight from the occupancy count
   assign o_in_ready  = (count_ff != DEPTH[AW:0]);
   assign o_out_valid = (count_ff != {(AW+1){1'b0}});
   assign o_out_data  = mem[rd_ptr_ff];

   // storage has no reset: contents are only read when counted valid
   always @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= i_in_data;
      end
   end

   // pointers wrap naturally since depth is a power of two
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// [core/dac_front_regs.vh]
// constants for the dac input latch and segment decoder
`ifndef DAC_FRONT_REGS_VH
`define DAC_FRONT_REGS_VH

// code layout: unsigned binary, bit 11 heaviest
`define CODE_W        12
`define TOP_MSB       11
`define TOP_LSB       6
`define MID_MSB       5
`define MID_LSB       4
`define BIN_MSB       3
`define BIN_LSB       0

// element counts per segment
`define TOP_ELEMS     63
`define MID_ELEMS     3
`define BIN_ELEMS     4
`define TOP_GRID      64

// capture buffer geometry
`define FIFO_DEPTH    32

// reset value of the applied code
`define CODE_RST      12'h000

// half-scale settling time, and the hold per applied code in cycles
`define CLK_PERIOD_NS 10
`define SETTLE_NS     2500
`define SETTLE_CYC    (`SETTLE_NS / `CLK_PERIOD_NS)
`define SETTLE_W      9

`endif

// [core/dac_input_latch_segment_decoder.v]
// strobe-driven code capture and 6x2x4 segment decoder of the dac
`timescale 1ns/100ps
`default_nettype none
`include "dac_front_regs.vh"

// Functional notes
// - strobe rising edge captures all twelve bits
// - code is unsigned binary, bit 11 heaviest
// - upper six bits drive thermometer top segment
// - bits 5 and 4 drive unary middle
// - four low bits drive binary elements directly
// - top elements follow symmetric two-dimensional order
// - conversions are started only by the strobe
// - selected elements to main, others to complement
module dac_input_latch_segment_decoder (
   // clock and reset
   input  wire                   i_ref_clk,
   input  wire                   i_rst,
   // pins from the host
   input  wire                   i_conv_strobe,
   input  wire [`CODE_W-1:0]     i_dac_code_in,
   // capture status
   output wire                   o_capture_ready,
   output reg                    o_overrun_ff,
   output reg                    o_conv_start_ff,
   output wire                   o_settling,
   output reg  [`CODE_W-1:0]     o_code_applied_ff,
   // element switches toward the main current output
   output reg  [`TOP_ELEMS-1:0]  o_top_main_current_out_ff,
   output reg  [`MID_ELEMS-1:0]  o_mid_main_current_out_ff,
   output reg  [`BIN_ELEMS-1:0]  o_bin_main_current_out_ff,
   // element switches toward the complement current output
   output wire [`TOP_ELEMS-1:0]  o_top_complement_current_out,
   output wire [`MID_ELEMS-1:0]  o_mid_complement_current_out,
   output wire [`BIN_ELEMS-1:0]  o_bin_complement_current_out
);

   // centre-outward position along one axis of the 8x8 array
   function [2:0] centre_out;
      input [2:0] idx;
      begin
         case (idx)
            3'h0:    centre_out = 3'h3;
            3'h1:    centre_out = 3'h4;
            3'h2:    centre_out = 3'h2;
            3'h3:    centre_out = 3'h5;
            3'h4:    centre_out = 3'h1;
            3'h5:    centre_out = 3'h6;
            3'h6:    centre_out = 3'h0;
            default: centre_out = 3'h7;
         endcase
      end
   endfunction

   // grid cell switched on at step s: rows walk centre-out, columns
   // shift diagonally so each row and column fills evenly; step 63
   // lands on the spare cell 63, which carries no element
   function [5:0] step_cell;
      input [5:0] s;
      reg   [2:0] row;
      reg   [2:0] col;
      begin
         row       = centre_out(s[2:0]);
         col       = centre_out(s[5:3] + s[2:0] + 3'h1);
         step_cell = {row, col};
      end
   endfunction

   // two-flop synchronisers for the strobe and the code pins; the third
   // strobe flop only remembers the last synced level for the edge test
   // hazard: code bits may be mid-change as they are first sampled, but the
   // host keeps them still around its strobe edge, so the word seen two
   // edges later has settled along with the strobe
   reg                 strobe_s1_ff;
   reg                 strobe_s2_ff;
   reg                 strobe_s3_ff;
   reg [`CODE_W-1:0]   code_s1_ff;
   reg [`CODE_W-1:0]   code_s2_ff;

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         strobe_s1_ff <= 1'b0;
         strobe_s2_ff <= 1'b0;
         strobe_s3_ff <= 1'b0;
         code_s1_ff   <= `CODE_RST;
         code_s2_ff   <= `CODE_RST;
      end else begin
         strobe_s1_ff <= i_conv_strobe;
         strobe_s2_ff <= strobe_s1_ff;
         strobe_s3_ff <= strobe_s2_ff;
         code_s1_ff   <= i_dac_code_in;
         code_s2_ff   <= code_s1_ff;
      end
   end

   // one capture per rising edge; a strobe left high captures once,
   // so the host must drop it before the next request; a strobe that is
   // still high as reset ends gives exactly one capture
   wire strobe_rise = strobe_s2_ff & ~strobe_s3_ff;

   // code and strobe travel through equal depth, so the captured word
   // is the one present at the edge; the buffer absorbs up to 32 requests
   // made while a long hold is running
   wire                fifo_in_ready;
   wire                fifo_out_valid;
   wire [`CODE_W-1:0]  fifo_out_data;
   wire                drain;

   assign o_capture_ready = fifo_in_ready;

   code_fifo #(
      .WIDTH (`CODE_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_code_fifo (
      .i_ref_clk   (i_ref_clk),
      .i_rst       (i_rst),
      .i_in_valid  (strobe_rise),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (code_s2_ff),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (drain),
      .o_out_data  (fifo_out_data)
   );

   // overrun pulse: an edge seen while the buffer is full is dropped;
   // the pins cannot stall the host, so this pulse and the ready level
   // are the only trace of a lost request
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_overrun_ff <= 1'b0;
      end else begin
         o_overrun_ff <= strobe_rise & ~fifo_in_ready;
      end
   end

   // each applied code is held for the settling time before the next
   // is taken; this is what lets the buffer fill under bursts; the
   // counter reads zero when idle, which is also its reset value
   reg [`SETTLE_W-1:0] settle_cnt_ff;

   // counter load, cut to the counter's width on purpose; the hold is
   // sized for a half-scale step, so small steps wait longer than needed
   localparam [31:0] SETTLE_FULL = `SETTLE_CYC;

   assign o_settling = (settle_cnt_ff != {`SETTLE_W{1'b0}});
   assign drain      = fifo_out_valid & ~o_settling;

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         settle_cnt_ff <= {`SETTLE_W{1'b0}};
      end else if (drain) begin
         settle_cnt_ff <= SETTLE_FULL[`SETTLE_W-1:0];
      end else if (o_settling) begin
         settle_cnt_ff <= settle_cnt_ff - 1'b1;
      end
   end

   // decode the word about to be applied; decoding sits before the
   // output registers so the switches themselves come straight from flops
   wire [5:0] top_code = fifo_out_data[`TOP_MSB:`TOP_LSB];
   wire [1:0] mid_code = fifo_out_data[`MID_MSB:`MID_LSB];

   reg  [`TOP_GRID-1:0]  top_grid;
   reg  [`MID_ELEMS-1:0] nxt_mid;
   integer               s;

   // thermometer over the grid: step s is on when below the top code;
   // a rising code only ever adds cells, so the top segment is monotonic
   // by construction, and the spare cell 63 is never lit
   always @* begin
      top_grid = {`TOP_GRID{1'b0}};
      for (s = 0; s < `TOP_ELEMS; s = s + 1) begin
         top_grid[step_cell(s[5:0])] = (s[5:0] < top_code);
      end
   end

   // middle unary: code n turns on n equal elements, always filled from
   // bit 0 so that a step of one code adds exactly one element and never
   // swaps one element for another
   always @* begin
      nxt_mid = {`MID_ELEMS{1'b0}};
      case (mid_code)
         2'h1:    nxt_mid = 3'h1;
         2'h2:    nxt_mid = 3'h3;
         2'h3:    nxt_mid = 3'h7;
         default: nxt_mid = 3'h0;
      endcase
   end

   // element switches update only when a captured word is applied; all
   // of them move on the same edge so no mixed old and new code reaches
   // the current switches; reset parks every element on the complement
   // side, which is the zero-code output
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_code_applied_ff         <= `CODE_RST;
         o_top_main_current_out_ff <= {`TOP_ELEMS{1'b0}};
         o_mid_main_current_out_ff <= {`MID_ELEMS{1'b0}};
         o_bin_main_current_out_ff <= {`BIN_ELEMS{1'b0}};
         o_conv_start_ff           <= 1'b0;
      end else begin
         o_conv_start_ff <= drain;
         if (drain) begin
            o_code_applied_ff         <= fifo_out_data;
            o_top_main_current_out_ff <= top_grid[`TOP_ELEMS-1:0];
            o_mid_main_current_out_ff <= nxt_mid;
            o_bin_main_current_out_ff <= fifo_out_data[`BIN_MSB:`BIN_LSB];
         end
      end
   end

   // every element not steered to main goes to the complement output;
   // taken from the main registers through an inverter only, so the two
   // sides of a switch can never both be on or both be off
   assign o_top_complement_current_out = ~o_top_main_current_out_ff;
   assign o_mid_complement_current_out = ~o_mid_main_current_out_ff;
   assign o_bin_complement_current_out = ~o_bin_main_current_out_ff;

endmodule

`default_nettype wire

// [verif/dac_front_properties.sv]
// port checker for the dac code latch and segment decoder
`timescale 1ns/100ps
`default_nettype none
`include "dac_front_regs.vh"
module dac_front_properties (
   // clock and reset
   input wire logic                  i_ref_clk,
   input wire logic                  i_rst,
   // host pins
   input wire logic                  i_conv_strobe,
   input wire logic [`CODE_W-1:0]    i_dac_code_in,
   // status and switches
   input wire logic                  o_capture_ready,
   input wire logic                  o_overrun_ff,
   input wire logic                  o_conv_start_ff,
   input wire logic                  o_settling,
   input wire logic [`CODE_W-1:0]    o_code_applied_ff,
   input wire logic [`TOP_ELEMS-1:0] o_top_main_current_out_ff,
   input wire logic [`MID_ELEMS-1:0] o_mid_main_current_out_ff,
   input wire logic [`BIN_ELEMS-1:0] o_bin_main_current_out_ff,
   input wire logic [`TOP_ELEMS-1:0] o_top_complement_current_out,
   input wire logic [`MID_ELEMS-1:0] o_mid_complement_current_out,
   input wire logic [`BIN_ELEMS-1:0] o_bin_complement_current_out
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // a new code is applied, then at least eight quiet cycles follow
   sequence start_s; o_conv_start_ff; endsequence
   sequence quiet_s; !o_conv_start_ff [*8]; endsequence
   top_count_a : assert property ($countones(o_top_main_current_out_ff) == o_code_applied_ff[11:6])
      else $error("top element count differs from code");
   mid_therm_a : assert property (o_mid_main_current_out_ff == (3'b111 >> (2'd3 - o_code_applied_ff[5:4])))
      else $error("middle thermometer wrong");
   bin_direct_a : assert property (o_bin_main_current_out_ff == o_code_applied_ff[3:0])
      else $error("binary elements differ from code");
   top_steer_a : assert property (o_top_complement_current_out == ~o_top_main_current_out_ff)
      else $error("top complement not inverse");
   low_steer_a : assert property ({o_mid_complement_current_out, o_bin_complement_current_out} == ~{o_mid_main_current_out_ff, o_bin_main_current_out_ff})
      else $error("low complement not inverse");
   code_hold_a : assert property (!o_conv_start_ff |-> $stable(o_code_applied_ff) && $stable(o_top_main_current_out_ff))
      else $error("outputs moved without a start");
   start_hold_a : assert property (start_s |-> o_settling ##1 quiet_s)
      else $error("applied code not held");
   overrun_full_a : assert property (o_overrun_ff |-> !$past(o_capture_ready))
      else $error("overrun while not full");
endmodule
bind dac_input_latch_segment_decoder dac_front_properties i_dac_front_properties (.i_ref_clk,
   .i_rst, .i_conv_strobe, .i_dac_code_in, .o_capture_ready, .o_overrun_ff, .o_conv_start_ff,
   .o_settling, .o_code_applied_ff, .o_top_main_current_out_ff, .o_mid_main_current_out_ff,
   .o_bin_main_current_out_ff, .o_top_complement_current_out, .o_mid_complement_current_out,
   .o_bin_complement_current_out);
`default_nettype wire

// [verif/host_model.sv]
// host model driving the code pins and the conversion strobe
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // clock
   input  wire logic        i_ref_clk,
   // pins toward the converter
   output var  logic        o_strobe,
   output var  logic [11:0] o_code
);
   initial begin
      o_strobe = 1'b0;
      o_code   = 12'h000;
   end
   // one request: two cycles high, two seen low before the next
   task automatic send(input logic [11:0] c);
      @(posedge i_ref_clk);
      o_code   <= c;
      o_strobe <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      o_strobe <= 1'b0;
      o_code   <= ~c; // hold over: stale value must not leak through
      @(posedge i_ref_clk);
   endtask
endmodule
`default_nettype wire

// [verif/test_dac_input_latch_segment_decoder.sv]
// self-checking bench for the dac code latch and segment decoder
`timescale 1ns/100ps
`default_nettype none
`include "dac_front_regs.vh"
module test_dac_input_latch_segment_decoder;
   localparam logic [23:0] CO = 24'he31aa3; // centre-out order 3,4,2,5,1,6,0,7
   logic        i_ref_clk = 1'b0;
   logic        i_rst     = 1'b1;
   wire  logic  i_conv_strobe, o_capture_ready, o_overrun_ff, o_conv_start_ff, o_settling;
   wire  logic [11:0] i_dac_code_in, o_code_applied_ff;
   wire  logic [62:0] o_top_main_current_out_ff, o_top_complement_current_out;
   wire  logic [2:0]  o_mid_main_current_out_ff, o_mid_complement_current_out;
   wire  logic [3:0]  o_bin_main_current_out_ff, o_bin_complement_current_out;
   logic [11:0] exp_q[$];
   logic [11:0] ce;
   logic [11:0] ae;
   int          last_start = -1000;
   int          bad_count, tests_run, drops, cycles, k;
   always #5 i_ref_clk = ~i_ref_clk;
   host_model i_host_model (.i_ref_clk, .o_strobe(i_conv_strobe), .o_code(i_dac_code_in));
   dac_input_latch_segment_decoder i_dac_input_latch_segment_decoder (.i_ref_clk, .i_rst,
      .i_conv_strobe, .i_dac_code_in, .o_capture_ready, .o_overrun_ff, .o_conv_start_ff,
      .o_settling, .o_code_applied_ff, .o_top_main_current_out_ff, .o_mid_main_current_out_ff,
      .o_bin_main_current_out_ff, .o_top_complement_current_out,
      .o_mid_complement_current_out, .o_bin_complement_current_out);
   // top cells lit for t steps, cell index row*8+col
   function automatic logic [62:0] exp_top(input logic [5:0] t);
      logic [62:0] r;
      r = '0;
      for (int s = 0; s < t; s++)
         r[{CO[3*(s%8) +: 3], CO[3*((s/8 + s%8 + 1)%8) +: 3]}] = 1'b1;
      return r;
   endfunction
   task automatic chk(input logic [62:0] got, input logic [62:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // wait until every queued code has been applied and held
   task automatic drain;
      for (int n = 0; n < 12000 && (exp_q.size() != 0 || o_settling !== 1'b0); n++)
         @(posedge i_ref_clk);
      if (exp_q.size() != 0 || o_settling !== 1'b0) begin
         bad_count++;
         $display("CHECK FAILED at %0t: drain timed out", $time);
      end
   endtask
   // every applied code is compared with the reference model; the ceiling cuts a hang
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         wrap_up();
      end else begin
         if (o_overrun_ff === 1'b1) drops++;
         if (i_rst === 1'b0 && o_conv_start_ff === 1'b1) begin
            ae = (exp_q.size() != 0) ? exp_q.pop_front() : 12'hxxx;
            chk(o_code_applied_ff, ae, "applied code");
            chk(o_top_main_current_out_ff, exp_top(ae[11:6]), "top cells");
            chk(o_mid_main_current_out_ff, 3'b111 >> (2'd3 - ae[5:4]), "middle");
            chk(o_bin_main_current_out_ff, ae[3:0], "binary");
            chk(o_top_complement_current_out, ~exp_top(ae[11:6]), "top complement");
            chk({o_mid_complement_current_out, o_bin_complement_current_out},
                7'(~{3'(3'b111 >> (2'd3 - ae[5:4])), ae[3:0]}), "low complement");
            chk(o_settling, 1'b1, "hold started");
            chk(cycles - last_start >= `SETTLE_CYC + 1, 1'b1, "hold time");
            last_start = cycles;
         end
      end
   end
   initial begin
      void'($urandom(32'hed46eae3));
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      // boundary codes, then random ones, each applied alone
      for (k = 0; k < 12; k++) begin
         ce = (k < 6) ? 12'({12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h030, 12'h00f} >> (12*(5-k)))
                      : 12'($urandom);
         exp_q.push_back(ce);
         i_host_model.send(ce);
         drain();
      end
      $display("single codes done");
      // burst while settling: one applied, 32 queued, last two refused
      for (k = 0; k < 35; k++) begin
         ce = 12'($urandom);
         if (k < 33) exp_q.push_back(ce);
         i_host_model.send(ce);
      end
      @(negedge i_ref_clk);
      chk(o_capture_ready, 1'b0, "buffer full");
      drain();
      @(negedge i_ref_clk);
      chk(o_capture_ready, 1'b1, "buffer empty");
      chk(drops, 2, "refused strobes");
      chk(exp_q.size(), 0, "codes left over");
      $display("burst done");
      wrap_up();
   end
endmodule
`default_nettype wire
